// file: scs_top.sv
// Purpose: System clock source selection and derivation
// Assumes: Clock pins are sampled at 200 MHz; config ports are sys_clk logic
// Notes:   The system clock leaves as a sampled level, not a real clock tree
`include "scs_map.svh"

module scs_top (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic                    external_clock_input,
    input  wire logic                    crystal_input,
    input  wire logic                    internal_clock_source,
    input  wire logic                    wakeup_clock_source,
    input  wire logic [1:0]              clock_source_select,
    input  wire logic                    vco_bypass,
    input  wire logic                    base_clock_select,
    input  wire logic [`SCS_K1_W-1:0]    prescaler_divider_field,
    input  wire logic [`SCS_P_W-1:0]     pll_input_divider_field,
    input  wire logic [`SCS_N_W-1:0]     pll_multiplier_field,
    input  wire logic [`SCS_K2_W-1:0]    pll_output_divider_field,
    input  wire logic [1:0]              vco_band_select,
    output logic                         system_clock_out,
    output scs_pkg::scs_mode_t           active_mode,
    output logic [1:0]                   vco_band_active,
    output logic                         pll_locked
);

    // Field plus one, at divider width
    function automatic logic [`SCS_FACT_W-1:0] plus_one(input logic [`SCS_FACT_W-1:0] f);
        return f + `SCS_FACT_W'(1);
    endfunction

    // Level of the clock that a mode would deliver
    function automatic logic mode_level(input scs_pkg::scs_mode_t m,
                                        input logic wake_l, input logic presc_l,
                                        input logic pll_l,  input logic ext_l);
        logic lvl;
        lvl = 1'b0;
        unique case (m)
            scs_pkg::SCS_MODE_WAKE:   lvl = wake_l;
            scs_pkg::SCS_MODE_PRESC:  lvl = presc_l;
            scs_pkg::SCS_MODE_PLL:    lvl = pll_l;
            scs_pkg::SCS_MODE_DIRECT: lvl = ext_l;
        endcase
        return lvl;
    endfunction

    // Phase increment limits of a VCO band
    function automatic logic [`SCS_ACC_W-1:0] band_limit(input logic [1:0] band,
                                                         input logic       upper);
        logic [`SCS_ACC_W-1:0] lim;
        lim = upper ? `SCS_BAND0_MAX : `SCS_BAND0_MIN;
        if (band == `SCS_BAND_HIGH)
            lim = upper ? `SCS_BAND1_MAX : `SCS_BAND1_MIN;
        return lim;
    endfunction

    scs_pkg::scs_src_t src_raw;
    scs_pkg::scs_src_t src;

    assign src_raw.ext  = external_clock_input;
    assign src_raw.xtal = crystal_input;
    assign src_raw.intc = internal_clock_source;
    assign src_raw.wake = wakeup_clock_source;

    scs_sync #(
        .W        (4)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in (src_raw),
        .sync_out (src)
    );

    // Base clock shared by prescaler and PLL input
    logic base_lvl;
    assign base_lvl = base_clock_select ? src.intc : src.xtal;

    // Prescaler path
    logic [`SCS_FACT_W-1:0] k1_factor;
    logic                   k1_lvl;

    // 10-bit field caps K1 at 1024
    assign k1_factor = plus_one(`SCS_FACT_W'(prescaler_divider_field));

    scs_div u_k1 (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .level_in  (base_lvl),
        .factor    (k1_factor),
        .level_out (k1_lvl)
    );

    // Select decode
    logic               sel_direct;
    logic               sel_wake;
    logic               sel_rsvd;
    logic               sel_base;
    scs_pkg::scs_mode_t mode_q;

    assign sel_direct = (clock_source_select == `SCS_SEL_DIRECT);
    assign sel_wake   = (clock_source_select == `SCS_SEL_WAKE);
    assign sel_rsvd   = (clock_source_select == `SCS_SEL_RSVD);
    assign sel_base   = (clock_source_select == `SCS_SEL_PRESC);

    // PLL enable and factors
    logic pll_en;
    logic pll_run;
    assign pll_en = sel_base && !vco_bypass;
    // Keep the loop running until the switch away completes; a frozen
    // output divider could otherwise sit high and block the change-over
    assign pll_run = pll_en || (mode_q == scs_pkg::SCS_MODE_PLL);

    logic [`SCS_FACT_W-1:0] p_factor;
    logic [`SCS_FACT_W-1:0] n_factor;
    logic [`SCS_FACT_W-1:0] k2_factor;

    assign p_factor  = plus_one(`SCS_FACT_W'(pll_input_divider_field));
    assign n_factor  = plus_one(`SCS_FACT_W'(pll_multiplier_field));
    assign k2_factor = plus_one(`SCS_FACT_W'(pll_output_divider_field));

    // Band register ignores reserved codes, keeping the last legal band
    logic [1:0] band_q;
    logic       band_legal;
    assign band_legal = !vco_band_select[1];

    logic [`SCS_ACC_W-1:0] inc_min;
    logic [`SCS_ACC_W-1:0] inc_max;
    assign inc_min = band_limit(band_q, 1'b0);
    assign inc_max = band_limit(band_q, 1'b1);

    // Numerically controlled VCO
    logic [`SCS_ACC_W-1:0] acc_q;
    logic [`SCS_ACC_W-1:0] inc_q;
    logic [`SCS_ACC_W-1:0] inc_d;
    logic                  vco_lvl;
    logic                  vco_prev_q;
    logic                  vco_rise;
    logic                  in_prev_q;
    logic                  in_rise;

    assign vco_lvl  = acc_q[`SCS_ACC_W-1];
    assign vco_rise = vco_lvl & ~vco_prev_q;
    assign in_rise  = base_lvl & ~in_prev_q;

    // Frequency error: input edges weigh N, VCO edges weigh P,
    // so the loop settles where f_vco * P equals f_in * N
    logic signed [`SCS_ERR_W-1:0] err_q;
    logic signed [`SCS_ERR_W+1:0] err_sum;
    logic signed [`SCS_ERR_W-1:0] err_d;

    assign err_sum = (`SCS_ERR_W+2)'(err_q)
                   + (in_rise  ? (`SCS_ERR_W+2)'(n_factor) : '0)
                   - (vco_rise ? (`SCS_ERR_W+2)'(p_factor) : '0);

    // Saturate so a long outage cannot wrap the error sign
    logic err_over;
    logic err_under;
    assign err_over  = err_sum > (`SCS_ERR_W+2)'(signed'(`SCS_ERR_MAX));
    assign err_under = err_sum < (`SCS_ERR_W+2)'(signed'(`SCS_ERR_MIN));
    assign err_d = err_over  ? signed'(`SCS_ERR_MAX)
                 : err_under ? signed'(`SCS_ERR_MIN)
                 : err_sum[`SCS_ERR_W-1:0];

    // Tracking step pacing
    logic [`SCS_TRK_W-1:0] trk_q;
    logic                  trk_en;
    assign trk_en = (trk_q == `SCS_TRK_W'(`SCS_TRACK_CYC - 1));

    // One increment step per tracking pulse keeps frequency changes smooth
    logic [`SCS_ACC_W-1:0] inc_step;
    assign inc_step = (err_q > 0 && inc_q < inc_max) ? inc_q + `SCS_ACC_W'(1)
                    : (err_q < 0 && inc_q > inc_min) ? inc_q - `SCS_ACC_W'(1)
                    : inc_q;

    // Clamp into the band when the band changes
    assign inc_d = (inc_q < inc_min) ? inc_min
                 : (inc_q > inc_max) ? inc_max
                 : trk_en ? inc_step : inc_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            band_q <= `SCS_BAND_LOW;
        end else if (band_legal) begin
            band_q <= vco_band_select;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            trk_q <= '0;
        end else begin
            trk_q <= trk_en ? '0 : trk_q + `SCS_TRK_W'(1);
        end
    end

    // Disabled PLL is held at rest so it restarts from a known point
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q      <= '0;
            inc_q      <= `SCS_BAND0_MIN;
            err_q      <= '0;
            in_prev_q  <= 1'b0;
            vco_prev_q <= 1'b0;
        end else if (!pll_run) begin
            acc_q      <= '0;
            inc_q      <= inc_min;
            err_q      <= '0;
            in_prev_q  <= base_lvl;
            vco_prev_q <= 1'b0;
        end else begin
            acc_q      <= acc_q + inc_q;
            inc_q      <= inc_d;
            err_q      <= err_d;
            in_prev_q  <= base_lvl;
            vco_prev_q <= vco_lvl;
        end
    end

    // Output divider K2 on the VCO level
    logic k2_lvl;

    scs_div u_k2 (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .level_in  (vco_lvl),
        .factor    (k2_factor),
        .level_out (k2_lvl)
    );

    // Lock window on the frequency error
    logic err_small;
    assign err_small = (err_q < signed'(`SCS_LOCK_TOL)) && (err_q > -signed'(`SCS_LOCK_TOL));

    // Requested mode; reserved select keeps the current mode
    scs_pkg::scs_mode_t mode_req;

    assign mode_req = sel_direct ? scs_pkg::SCS_MODE_DIRECT
                    : sel_wake   ? scs_pkg::SCS_MODE_WAKE
                    : sel_rsvd   ? mode_q
                    : vco_bypass ? scs_pkg::SCS_MODE_PRESC
                    : scs_pkg::SCS_MODE_PLL;

    logic cand_lvl;
    logic cur_lvl;
    logic switch_ok;

    assign cand_lvl = mode_level(mode_req, src.wake, k1_lvl, k2_lvl, src.ext);
    assign cur_lvl  = mode_level(mode_q,   src.wake, k1_lvl, k2_lvl, src.ext);

    // Change over only while both old and new clocks sit low,
    // so no high phase is cut short; the low phase can be shorter than either clock's
    assign switch_ok = (mode_req != mode_q) && !system_clock_out && !cur_lvl && !cand_lvl;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= scs_pkg::SCS_MODE_WAKE;
        end else if (switch_ok) begin
            mode_q <= mode_req;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            system_clock_out <= 1'b0;
            active_mode      <= scs_pkg::SCS_MODE_WAKE;
        end else begin
            system_clock_out <= switch_ok ? 1'b0 : cur_lvl;
            active_mode      <= mode_q;
        end
    end

    // Lock reports only while the loop is asked for, not during its run-out
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vco_band_active <= `SCS_BAND_LOW;
            pll_locked      <= 1'b0;
        end else begin
            vco_band_active <= band_q;
            pll_locked      <= pll_en && err_small;
        end
    end

endmodule

// file: scs_map.svh
// Purpose: Constants for the system clock source selector
// Assumes: sys_clk at 200 MHz
// Notes:   Field widths beyond the prescaler are local choices
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH

// Source select codes
`define SCS_SEL_WAKE        2'h0
`define SCS_SEL_RSVD        2'h1
`define SCS_SEL_PRESC       2'h2
`define SCS_SEL_DIRECT      2'h3

// Field widths
`define SCS_K1_W            10
`define SCS_P_W             4
`define SCS_N_W             8
`define SCS_K2_W            7
`define SCS_FACT_W          12

// VCO band codes
`define SCS_BAND_LOW        2'h0
`define SCS_BAND_HIGH       2'h1

// Phase increment limits per band, in 1/65536 of sys_clk
`define SCS_ACC_W           16
`define SCS_ERR_W           16
`define SCS_BAND0_MIN       16'h0400
`define SCS_BAND0_MAX       16'h3000
`define SCS_BAND1_MIN       16'h0800
`define SCS_BAND1_MAX       16'h6000
`define SCS_ERR_MAX         16'h7000
`define SCS_ERR_MIN         16'h9000
`define SCS_LOCK_TOL        16'h0040

// Tracking step interval
`define SCS_CLK_PERIOD_NS   5
`define SCS_TRACK_NS        100
`define SCS_TRACK_CYC       (`SCS_TRACK_NS / `SCS_CLK_PERIOD_NS)
`define SCS_TRK_W           8

`endif

// file: scs_pkg.sv
// Purpose: Types for the system clock source selector
// Assumes: Nothing beyond the map header
// Notes:   Mode codes are one-hot
package scs_pkg;

    typedef enum logic [3:0] {
        SCS_MODE_WAKE   = 4'h1,
        SCS_MODE_PRESC  = 4'h2,
        SCS_MODE_PLL    = 4'h4,
        SCS_MODE_DIRECT = 4'h8
    } scs_mode_t;

    typedef struct packed {
        logic ext;
        logic xtal;
        logic intc;
        logic wake;
    } scs_src_t;

endpackage

// file: scs_sync.sv
// Purpose: Two-flop synchroniser for asynchronous clock pins
// Assumes: Inputs are levels from outside the sys_clk domain
// Notes:   First stage feeds only the second stage
module scs_sync #(
    parameter int W = 4
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// file: scs_div.sv
// Purpose: Integer divider of a sampled clock level
// Assumes: level_in toggles slower than half of sys_clk
// Notes:   Factor 1 passes the level through, keeping its duty cycle
`include "scs_map.svh"

module scs_div (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic                    level_in,
    input  wire logic [`SCS_FACT_W-1:0]  factor,
    output logic                         level_out
);

    logic                   prev_q;
    logic [`SCS_FACT_W-1:0] cnt_q;
    logic [`SCS_FACT_W-1:0] cnt_d;
    logic [`SCS_FACT_W-1:0] half;
    logic                   rise;
    logic                   out_d;

    assign rise  = level_in & ~prev_q;
    assign half  = factor >> 1;
    assign cnt_d = (cnt_q >= factor - `SCS_FACT_W'(1)) ? '0 : cnt_q + `SCS_FACT_W'(1);
    // Odd factors give the shorter half high
    assign out_d = (factor <= `SCS_FACT_W'(1)) ? level_in : (cnt_q < half);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q    <= 1'b0;
            cnt_q     <= '0;
            level_out <= 1'b0;
        end else begin
            prev_q    <= level_in;
            if (rise)
                cnt_q <= cnt_d;
            level_out <= out_d;
        end
    end

endmodule

// file: scs_top_asserts.sv
// Purpose: Port-level checks of the system clock source selector
// Assumes: Bound to scs_top; one sys_clk domain
// Notes:   Direct and wakeup paths carry three cycles of latency
`include "scs_map.svh"
module scs_chk (
    input wire logic               sys_clk,
    input wire logic               rst_n,
    input wire logic               external_clock_input,
    input wire logic               wakeup_clock_source,
    input wire logic [1:0]         clock_source_select,
    input wire logic               vco_bypass,
    input wire logic [1:0]         vco_band_select,
    input wire logic               system_clock_out,
    input wire scs_pkg::scs_mode_t active_mode,
    input wire logic [1:0]         vco_band_active,
    input wire logic               pll_locked
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Mode must have settled before the pin can be traced through the sync stages
    sequence s_direct_held;
        (active_mode == scs_pkg::SCS_MODE_DIRECT) [*4];
    endsequence
    sequence s_wake_held;
        (active_mode == scs_pkg::SCS_MODE_WAKE) [*4];
    endsequence
    sequence s_band_high_held;
        (vco_band_select == 2'h1 && active_mode == scs_pkg::SCS_MODE_PLL) [*3];
    endsequence

    a_direct_follows_pin: assert property (
        s_direct_held |-> system_clock_out == $past(external_clock_input, 3))
        else $error("direct output does not follow pin");
    a_wake_follows_src: assert property (
        s_wake_held |-> system_clock_out == $past(wakeup_clock_source, 3))
        else $error("wakeup output does not follow source");
    a_direct_reached: assert property (
        clock_source_select == 2'h3 |-> ##[0:300]
        (active_mode == scs_pkg::SCS_MODE_DIRECT || clock_source_select != 2'h3))
        else $error("direct mode never taken");
    a_reserved_keeps_mode: assert property (
        (clock_source_select == 2'h1) [*3] |-> $stable(active_mode))
        else $error("reserved select changed mode");
    a_mode_one_hot: assert property ($onehot(active_mode))
        else $error("mode not one-hot");
    // Three samples: a legal code just before the reserved one still lands
    a_band_ignores_rsvd: assert property (
        (vco_band_select[1]) [*3] |-> $stable(vco_band_active))
        else $error("reserved band code taken");
    a_band_never_rsvd: assert property (!vco_band_active[1])
        else $error("reserved band active");
    a_band_high_taken: assert property (
        s_band_high_held |-> vco_band_active == 2'h1)
        else $error("upper band not taken");
    // Lock follows the PLL request, which leads the mode change-over
    a_lock_only_pll: assert property (
        (clock_source_select != 2'h2 || vco_bypass) [*2] |-> !pll_locked)
        else $error("lock while pll not requested");
endmodule

bind scs_top scs_chk chk_u (
    .sys_clk              (sys_clk),
    .rst_n                (rst_n),
    .external_clock_input (external_clock_input),
    .wakeup_clock_source  (wakeup_clock_source),
    .clock_source_select  (clock_source_select),
    .vco_bypass           (vco_bypass),
    .vco_band_select      (vco_band_select),
    .system_clock_out     (system_clock_out),
    .active_mode          (active_mode),
    .vco_band_active      (vco_band_active),
    .pll_locked           (pll_locked)
);

// file: test_scs_top.sv
// Purpose: Self-checking bench for the clock source selector
// Assumes: Source clocks are made from a sys_clk phase counter
// Notes:   Rates are edge counts over a window, one edge of slack
`include "scs_map.svh"
module test_scs_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic                 sys_clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic [6:0]           cnt_q = 7'h00;
    logic                 external_clock_input, crystal_input;
    logic                 internal_clock_source, wakeup_clock_source;
    logic [1:0]           clock_source_select = 2'h0;
    logic                 vco_bypass = 1'b1;
    logic                 base_clock_select = 1'b0;
    logic [`SCS_K1_W-1:0] prescaler_divider_field = 10'h000;
    logic [`SCS_P_W-1:0]  pll_input_divider_field = 4'h0;
    logic [`SCS_N_W-1:0]  pll_multiplier_field = 8'h00;
    logic [`SCS_K2_W-1:0] pll_output_divider_field = 7'h00;
    logic [1:0]           vco_band_select = 2'h0;
    logic                 system_clock_out, pll_locked;
    logic [1:0]           vco_band_active;
    scs_pkg::scs_mode_t   active_mode;
    int                   n_fail = 0;
    int                   compares = 0;

    // Periods: ext 6, crystal 8, internal 16, wakeup 32 cycles
    assign external_clock_input = (cnt_q % 6) >= 3;
    assign crystal_input = cnt_q[2];
    assign internal_clock_source = cnt_q[3];
    assign wakeup_clock_source = cnt_q[4];

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) cnt_q <= 7'h00;
        else cnt_q <= (cnt_q == 7'h5F) ? 7'h00 : cnt_q + 7'h01;
    end

    scs_top dut_u (
        .sys_clk                  (sys_clk),
        .rst_n                    (rst_n),
        .external_clock_input     (external_clock_input),
        .crystal_input            (crystal_input),
        .internal_clock_source    (internal_clock_source),
        .wakeup_clock_source      (wakeup_clock_source),
        .clock_source_select      (clock_source_select),
        .vco_bypass               (vco_bypass),
        .base_clock_select        (base_clock_select),
        .prescaler_divider_field  (prescaler_divider_field),
        .pll_input_divider_field  (pll_input_divider_field),
        .pll_multiplier_field     (pll_multiplier_field),
        .pll_output_divider_field (pll_output_divider_field),
        .vco_band_select          (vco_band_select),
        .system_clock_out         (system_clock_out),
        .active_mode              (active_mode),
        .vco_band_active          (vco_band_active),
        .pll_locked               (pll_locked)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic cfg(input logic [1:0] sel, input logic byp, input logic base,
                       input logic [9:0] k1, input logic [3:0] p, input logic [7:0] n,
                       input logic [6:0] k2, input scs_pkg::scs_mode_t m);
        int i;
        @(posedge sys_clk);
        // All fields move on one edge, so no mixed setting is ever seen
        clock_source_select <= sel;
        vco_bypass <= byp;
        base_clock_select <= base;
        prescaler_divider_field <= k1;
        pll_input_divider_field <= p;
        pll_multiplier_field <= n;
        pll_output_divider_field <= k2;
        for (i = 0; i < 3000 && active_mode !== m; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (active_mode !== m) begin
            check(active_mode, m);
            wrap_up();
        end
        repeat (100) @(posedge sys_clk);
    endtask

    task automatic rate(input int win, input int exp);
        int r;
        logic last;
        r = 0;
        last = system_clock_out;
        repeat (win) begin
            @(posedge sys_clk);
            #1;
            if (system_clock_out && !last) r++;
            last = system_clock_out;
        end
        if (r >= exp - 1 && r <= exp + 1) r = exp;
        check(r, exp);
    endtask

    initial begin
        int i;
        repeat (5) @(posedge sys_clk);
        check({system_clock_out, pll_locked, vco_band_active}, 32'h0000_0000);
        check(active_mode, scs_pkg::SCS_MODE_WAKE);
        rst_n <= 1'b1;
        repeat (20) @(posedge sys_clk);
        rate(640, 20);
        cfg(2'h3, 1'b1, 1'b0, 10'h000, 4'h0, 8'h00, 7'h00, scs_pkg::SCS_MODE_DIRECT);
        rate(600, 100);
        cfg(2'h1, 1'b1, 1'b0, 10'h000, 4'h0, 8'h00, 7'h00, scs_pkg::SCS_MODE_DIRECT);
        rate(600, 100);
        cfg(2'h2, 1'b1, 1'b0, 10'h000, 4'h0, 8'h00, 7'h00, scs_pkg::SCS_MODE_PRESC);
        rate(800, 100);
        cfg(2'h2, 1'b1, 1'b0, 10'h002, 4'h0, 8'h00, 7'h00, scs_pkg::SCS_MODE_PRESC);
        rate(960, 40);
        cfg(2'h2, 1'b1, 1'b1, 10'h001, 4'h0, 8'h00, 7'h00, scs_pkg::SCS_MODE_PRESC);
        rate(960, 30);
        cfg(2'h2, 1'b0, 1'b0, 10'h000, 4'h7, 8'h00, 7'h00, scs_pkg::SCS_MODE_PLL);
        for (i = 0; i < 4000 && pll_locked !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        check(pll_locked, 1'b1);
        if (pll_locked !== 1'b1) wrap_up();
        rate(8192, 128);
        // Same VCO rate across the source change keeps the step small
        cfg(2'h2, 1'b0, 1'b1, 10'h000, 4'h3, 8'h00, 7'h00, scs_pkg::SCS_MODE_PLL);
        rate(8192, 128);
        cfg(2'h2, 1'b0, 1'b0, 10'h000, 4'hF, 8'h01, 7'h03, scs_pkg::SCS_MODE_PLL);
        rate(8192, 32);
        @(posedge sys_clk);
        vco_band_select <= 2'h1;
        repeat (5) @(posedge sys_clk);
        #1;
        check(vco_band_active, 2'h1);
        @(posedge sys_clk);
        vco_band_select <= 2'h2;
        repeat (5) @(posedge sys_clk);
        #1;
        check(vco_band_active, 2'h1);
        @(posedge sys_clk);
        vco_band_select <= 2'h0;
        // Largest factor last: its long high phase would stall any later switch
        cfg(2'h2, 1'b1, 1'b0, 10'h3FF, 4'h0, 8'h00, 7'h00, scs_pkg::SCS_MODE_PRESC);
        rate(32768, 4);
        wrap_up();
    end
endmodule
